// ### common/emb_pkg.sv
// Purpose: Shared constants for the external memory bus control block.
// Assumes: 200 MHz clock; 16-bit data, 23-bit address.
// Notes: Figures are the bus's own; widths fixed.
package emb_pkg;
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int WAIT_W = 3;
    localparam logic [ADDR_W-1:0] RESET_FETCH_ADDR = 23'h00FF80;
    localparam logic [15:0] ROM_BASE_ADDR = 16'hC000;
    localparam logic [WAIT_W-1:0] READY_MIN_WAITS = 3'h2;
    typedef enum logic [1:0] {EMB_SPACE_PROG, EMB_SPACE_DATA, EMB_SPACE_IO} emb_space_e;
endpackage : emb_pkg

// ### hdl/emb_sync.sv
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: One clock domain.
// Notes: First stage is read only by the second.
`timescale 1ns/100ps
`default_nettype none
module emb_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic d,
    output logic q
);
    logic s1_r;
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            s1_r <= d;
            q <= s1_r;
        end
    end
endmodule : emb_sync
`default_nettype wire

// ### hdl/emb_ctrl.sv
// Purpose: External memory and I/O bus control: selects, strobes, wait states, hold, boot mode.
// Assumes: Core issues one access at a time on req/req_ready; pins are synchronised here.
// Notes: Tristate pins are split into output and enable; enables high while driving.
// Behaviour
// - Space selects high unless accessing that space.
// - Select low exactly while address valid.
// - Controls released in hold or output disable.
// - Memory strobe low only for memory access.
// - I/O strobe low only for I/O access.
// - Read/write low only during writes.
// - Ready low extends access, resampled each cycle.
// - Ready detection only with two or more waits.
// - Ready not sampled before software waits end.
// - Hold request releases address, data, control.
// - Mode pin low maps ROM top 16K.
// - Mode pin high sends those addresses external.
// - Mode pin latched at reset; override allowed.
// - Fetch starts at 0FF80h after reset.
// - Interrupt acknowledge with vector fetch address.
// - Grant acknowledge while in hold.
// - Wait-complete active first to last wait, only with two or more waits.
// - Upper address lines only for program space.
// - Data bus released unless writing.
`timescale 1ns/100ps
`default_nettype none
module emb_ctrl (
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    output logic req_ready,
    input wire emb_pkg::emb_space_e req_space,
    input wire logic req_write,
    input wire logic req_vector,
    input wire logic [emb_pkg::ADDR_W-1:0] req_addr,
    input wire logic [emb_pkg::DATA_W-1:0] req_wdata,
    input wire logic [emb_pkg::WAIT_W-1:0] req_waits,
    output logic done,
    output logic [emb_pkg::DATA_W-1:0] rdata,
    output logic [emb_pkg::ADDR_W-1:0] fetch_start_addr,
    output logic rom_internal,
    input wire logic mode_override_en,
    input wire logic mode_override_val,
    output logic processor_mode_status,
    input wire logic rom_map_select,
    input wire logic ready_in,
    input wire logic hold_req_n,
    input wire logic output_disable_n,
    output logic [emb_pkg::ADDR_W-1:0] addr_o,
    output logic addr_oe,
    output logic [emb_pkg::DATA_W-1:0] data_o,
    output logic data_oe,
    input wire logic [emb_pkg::DATA_W-1:0] data_i,
    output logic program_space_select_n,
    output logic data_space_select_n,
    output logic io_space_select_n,
    output logic memory_strobe_n,
    output logic io_strobe_n,
    output logic rw_o,
    output logic ctrl_oe,
    output logic bus_grant_ack_n,
    output logic wait_states_complete_n,
    output logic irq_acknowledge_n
);
    import emb_pkg::*;

    typedef enum logic [1:0] {EMB_IDLE, EMB_WAIT, EMB_READY, EMB_HOLD} emb_state_e;

    emb_state_e state_r;
    logic ready_s;
    logic hold_s;
    logic off_s;
    logic mode_pin_s;
    logic mode_latched_r;
    logic reset_seen_r;
    logic [WAIT_W-1:0] wcnt_r;
    logic [WAIT_W-1:0] waits_r;
    emb_space_e space_r;
    logic write_r;
    logic vec_r;
    logic mode_eff;
    logic rom_hit;
    logic start;

    emb_sync #(.RST_VAL(1'b1)) u_sync_ready (.clk(clk), .reset(reset), .d(ready_in), .q(ready_s));
    emb_sync #(.RST_VAL(1'b1)) u_sync_hold (.clk(clk), .reset(reset), .d(hold_req_n), .q(hold_s));
    emb_sync #(.RST_VAL(1'b1)) u_sync_off (.clk(clk), .reset(reset), .d(output_disable_n), .q(off_s));
    // The strap sync keeps running through reset, so the latch sees the pin rather than a reset value.
    emb_sync #(.RST_VAL(1'b0)) u_sync_mode (.clk(clk), .reset(1'b0), .d(rom_map_select), .q(mode_pin_s));

    // The strap is caught while reset is held, so the last level before release wins.
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_latched_r <= mode_pin_s;
            reset_seen_r <= 1'b1;
        end else begin
            reset_seen_r <= 1'b0;
        end
    end

    assign mode_eff = mode_override_en ? mode_override_val : mode_latched_r;
    // Microcomputer mode keeps the top 16K program words on chip.
    assign rom_hit = (req_space == EMB_SPACE_PROG) && !mode_eff
                     && (req_addr[15:0] >= ROM_BASE_ADDR);
    // A hold request wins even when an access is pending start.
    assign start = (state_r == EMB_IDLE) && req_valid && !rom_hit && hold_s;

    always_ff @(posedge clk) begin
        if (reset) begin
            processor_mode_status <= 1'b0;
            rom_internal <= 1'b0;
            fetch_start_addr <= RESET_FETCH_ADDR;
        end else begin
            processor_mode_status <= mode_eff;
            rom_internal <= !mode_eff;
            if (reset_seen_r) begin
                fetch_start_addr <= RESET_FETCH_ADDR;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= EMB_IDLE;
            wcnt_r <= '0;
            waits_r <= '0;
            space_r <= EMB_SPACE_PROG;
            write_r <= 1'b0;
            vec_r <= 1'b0;
        end else begin
            unique case (state_r)
                EMB_IDLE: begin
                    if (!hold_s) begin
                        state_r <= EMB_HOLD;
                    end else if (start) begin
                        space_r <= req_space;
                        write_r <= req_write;
                        vec_r <= req_vector;
                        waits_r <= req_waits;
                        wcnt_r <= '0;
                        state_r <= EMB_WAIT;
                    end
                end
                EMB_WAIT: begin
                    if (wcnt_r >= waits_r) begin
                        // Ready matters only after the software waits, and only with two or more.
                        if (waits_r >= READY_MIN_WAITS) begin
                            state_r <= EMB_READY;
                        end else begin
                            state_r <= EMB_IDLE;
                        end
                    end else begin
                        wcnt_r <= wcnt_r + 3'h1;
                    end
                end
                EMB_READY: begin
                    if (ready_s) begin
                        state_r <= EMB_IDLE;
                    end
                end
                EMB_HOLD: begin
                    if (hold_s) begin
                        state_r <= EMB_IDLE;
                    end
                end
            endcase
        end
    end

    logic active;
    logic finishing;
    assign active = (state_r == EMB_WAIT) || (state_r == EMB_READY);
    assign finishing = ((state_r == EMB_WAIT) && (wcnt_r >= waits_r) && (waits_r < READY_MIN_WAITS))
                       || ((state_r == EMB_READY) && ready_s);

    always_ff @(posedge clk) begin
        if (reset) begin
            req_ready <= 1'b0;
            done <= 1'b0;
            rdata <= '0;
        end else begin
            req_ready <= (state_r == EMB_IDLE) && hold_s && !start;
            done <= finishing || ((state_r == EMB_IDLE) && req_valid && rom_hit && hold_s);
            if (finishing && !write_r) begin
                rdata <= data_i;
            end
        end
    end

    // Pin drive: selects, strobes and direction follow the registered access state.
    always_ff @(posedge clk) begin
        if (reset) begin
            addr_o <= '0;
            addr_oe <= 1'b0;
            data_o <= '0;
            data_oe <= 1'b0;
            program_space_select_n <= 1'b1;
            data_space_select_n <= 1'b1;
            io_space_select_n <= 1'b1;
            memory_strobe_n <= 1'b1;
            io_strobe_n <= 1'b1;
            rw_o <= 1'b1;
            ctrl_oe <= 1'b0;
            bus_grant_ack_n <= 1'b1;
            wait_states_complete_n <= 1'b1;
            irq_acknowledge_n <= 1'b1;
        end else begin
            if (start) begin
                // Upper lines carry address only for program space.
                addr_o <= (req_space == EMB_SPACE_PROG) ? req_addr
                          : {7'h00, req_addr[15:0]};
                data_o <= req_wdata;
            end
            addr_oe <= off_s && (state_r != EMB_HOLD) && !(state_r == EMB_IDLE && !hold_s);
            // A write in flight keeps the data bus until it ends; hold is only granted afterwards.
            data_oe <= off_s && ((start && req_write) || (active && write_r && !finishing));
            program_space_select_n <= !((start && req_space == EMB_SPACE_PROG)
                                        || (active && !finishing && space_r == EMB_SPACE_PROG));
            data_space_select_n <= !((start && req_space == EMB_SPACE_DATA)
                                     || (active && !finishing && space_r == EMB_SPACE_DATA));
            io_space_select_n <= !((start && req_space == EMB_SPACE_IO)
                                   || (active && !finishing && space_r == EMB_SPACE_IO));
            memory_strobe_n <= !((start && req_space != EMB_SPACE_IO)
                                 || (active && !finishing && space_r != EMB_SPACE_IO));
            io_strobe_n <= !((start && req_space == EMB_SPACE_IO)
                             || (active && !finishing && space_r == EMB_SPACE_IO));
            rw_o <= !((start && req_write) || (active && !finishing && write_r));
            ctrl_oe <= off_s && (state_r != EMB_HOLD) && !(state_r == EMB_IDLE && !hold_s);
            bus_grant_ack_n <= !((state_r == EMB_HOLD && !hold_s) || (state_r == EMB_IDLE && !hold_s));
            wait_states_complete_n <= !((start && req_waits >= READY_MIN_WAITS)
                                        || (state_r == EMB_WAIT && waits_r >= READY_MIN_WAITS
                                            && wcnt_r < waits_r - 3'h1));
            irq_acknowledge_n <= !((start && req_vector)
                                   || (active && !finishing && vec_r));
        end
    end

    AST_SEL_ONEHOT: assert property (@(posedge clk) disable iff (reset)
        $countones({~program_space_select_n, ~data_space_select_n, ~io_space_select_n}) <= 1)
        else $error("More than one space select active.");
    AST_STROBE_EXCL: assert property (@(posedge clk) disable iff (reset)
        !(!memory_strobe_n && !io_strobe_n))
        else $error("Memory and I/O strobes both active.");
    AST_IO_MATCH: assert property (@(posedge clk) disable iff (reset)
        io_strobe_n == io_space_select_n)
        else $error("I/O strobe differs from I/O select.");
    AST_HOLD_FLOAT: assert property (@(posedge clk) disable iff (reset)
        !bus_grant_ack_n |-> !ctrl_oe && !addr_oe && !data_oe)
        else $error("Bus driven while hold is granted.");
    AST_GRANT_IDLE: assert property (@(posedge clk) disable iff (reset)
        $fell(bus_grant_ack_n) |-> $past(state_r) != EMB_WAIT && $past(state_r) != EMB_READY)
        else $error("Hold granted during an access.");
    AST_WRITE_DRIVE: assert property (@(posedge clk) disable iff (reset)
        data_oe |-> !rw_o)
        else $error("Data bus driven outside a write.");
    AST_READY_GATE: assert property (@(posedge clk) disable iff (reset)
        state_r == EMB_READY |-> waits_r >= READY_MIN_WAITS)
        else $error("Ready checked with fewer than two waits.");
    AST_READY_HOLDS: assert property (@(posedge clk) disable iff (reset)
        state_r == EMB_READY && !ready_s |=> state_r == EMB_READY)
        else $error("Access ended while ready low.");
    AST_SEL_STRB: assert property (@(posedge clk) disable iff (reset)
        !memory_strobe_n |-> (!program_space_select_n || !data_space_select_n))
        else $error("Memory strobe without space select.");
endmodule : emb_ctrl
`default_nettype wire

// ### tb/emb_mem_model.sv
// Purpose: External memory and I/O device on the far side of the bus.
// Assumes: A strobe low marks an access; stall is the count of ready-low cycles.
// Notes: Undriven data shows the inverse of its last value, never a stale copy.
`timescale 1ns/100ps
`default_nettype none
module emb_mem_model (
    input wire logic clk,
    input wire logic memory_strobe_n,
    input wire logic io_strobe_n,
    input wire logic rw_o,
    input wire logic [3:0] addr,
    input wire logic [15:0] data_o,
    input wire logic [3:0] stall,
    output logic [15:0] data_i,
    output logic ready_in
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    logic [3:0] cnt = 4'h0;
    wire logic act = !memory_strobe_n || !io_strobe_n;
    always @(posedge clk) begin
        cnt <= act ? cnt + 4'h1 : 4'h0;
        if (act && !rw_o) begin
            mem[addr] <= data_o;
        end
        last <= data_i;
    end
    // Ready stays low until the device can finish, then rises for the rest of the access.
    assign ready_in = !(act && cnt < stall);
    assign data_i = (act && rw_o) ? mem[addr] : ~last;
endmodule : emb_mem_model
`default_nettype wire

// ### tb/external_memory_bus_control_tb.sv
// Purpose: Self-checking bench for the external bus control block.
// Assumes: Inputs change at the falling edge; the memory model answers the bus.
// Notes: Table rows cover ordinary accesses; hold, disable and boot mode follow.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module external_memory_bus_control_tb;
    import emb_pkg::*;
    typedef struct {emb_space_e sp; logic wr; logic vec; logic [2:0] w; logic [3:0] st; logic x;
        logic [22:0] a; logic [15:0] d;} emb_row_s;
    emb_row_s rows [7] = '{
        '{EMB_SPACE_DATA, 1'b1, 1'b0, 3'h0, 4'h0, 1'b0, 23'h000003, 16'h1234},
        '{EMB_SPACE_DATA, 1'b0, 1'b0, 3'h1, 4'h3, 1'b0, 23'h000003, 16'h1234},
        '{EMB_SPACE_IO, 1'b1, 1'b0, 3'h2, 4'h0, 1'b0, 23'h000005, 16'hBEEF},
        '{EMB_SPACE_IO, 1'b0, 1'b0, 3'h3, 4'h7, 1'b1, 23'h000005, 16'hBEEF},
        '{EMB_SPACE_PROG, 1'b0, 1'b1, 3'h0, 4'h0, 1'b0, 23'h7FC003, 16'h1234},
        '{EMB_SPACE_PROG, 1'b1, 1'b0, 3'h7, 4'h0, 1'b0, 23'h000001, 16'h5A5A},
        '{EMB_SPACE_DATA, 1'b0, 1'b0, 3'h4, 4'h1, 1'b0, 23'h000001, 16'h5A5A}};
    logic clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_vector = 1'b0;
    logic mode_override_en = 1'b0, mode_override_val = 1'b0, rom_map_select = 1'b1;
    logic hold_req_n = 1'b1, output_disable_n = 1'b1, ready_in, seen, hit;
    emb_space_e req_space = EMB_SPACE_DATA;
    logic [22:0] req_addr = 23'h000000, fetch_start_addr, addr_o;
    logic [15:0] req_wdata = 16'h0000, rdata, data_o, data_i;
    logic [2:0] req_waits = 3'h0;
    logic [3:0] stall = 4'h0;
    logic req_ready, done, rom_internal, processor_mode_status, addr_oe, data_oe, ctrl_oe, rw_o;
    logic program_space_select_n, data_space_select_n, io_space_select_n, memory_strobe_n;
    logic io_strobe_n, bus_grant_ack_n, wait_states_complete_n, irq_acknowledge_n;
    int fails = 0, check_count = 0, n, lat;
    emb_ctrl u_dut (.clk, .reset, .req_valid, .req_ready, .req_space, .req_write, .req_vector,
        .req_addr, .req_wdata, .req_waits, .done, .rdata, .fetch_start_addr, .rom_internal,
        .mode_override_en, .mode_override_val, .processor_mode_status, .rom_map_select,
        .ready_in, .hold_req_n, .output_disable_n, .addr_o, .addr_oe, .data_o, .data_oe,
        .data_i, .program_space_select_n, .data_space_select_n, .io_space_select_n,
        .memory_strobe_n, .io_strobe_n, .rw_o, .ctrl_oe, .bus_grant_ack_n,
        .wait_states_complete_n, .irq_acknowledge_n);
    emb_mem_model u_mem (.clk, .memory_strobe_n, .io_strobe_n, .rw_o, .addr(addr_o[3:0]),
        .data_o, .stall, .data_i, .ready_in);
    always #2.5 clk = ~clk;
    task give_verdict;
        if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task tick(input int lim);
        @(negedge clk);
        n++;
        if (n > lim) begin
            fails++;
            give_verdict;
        end
    endtask : tick
    task do_reset;
        reset = 1'b1;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
    endtask : do_reset
    // Offers a request and lowers valid only after the edge that takes it.
    task offer(input emb_space_e sp, input logic wr, vec, input logic [22:0] a);
        req_space = sp;
        req_write = wr;
        req_vector = vec;
        req_addr = a;
        req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1) tick(20);
        @(negedge clk);
        req_valid = 1'b0;
    endtask : offer
    task acc(input emb_row_s r, input logic h);
        logic [2:0] sel;
        sel = r.sp == EMB_SPACE_PROG ? 3'h3 : (r.sp == EMB_SPACE_DATA ? 3'h5 : 3'h6);
        req_waits = r.w;
        req_wdata = r.d;
        stall = r.st;
        offer(r.sp, r.wr, r.vec, r.a);
        hold_req_n = !h;
        n = 1;
        seen = 1'b0;
        while (done !== 1'b1) begin
            `CHK("selects", sel, {program_space_select_n, data_space_select_n, io_space_select_n})
            `CHK("strobes", {r.sp == EMB_SPACE_IO, r.sp != EMB_SPACE_IO}, {memory_strobe_n, io_strobe_n})
            `CHK("rw", !r.wr, rw_o)
            `CHK("addr", r.a[15:0], addr_o[15:0])
            if (r.sp == EMB_SPACE_PROG) `CHK("addr_hi", r.a[22:16], addr_o[22:16])
            `CHK("grant", 1'b1, bus_grant_ack_n)
            `CHK("irq_acknowledge_n", !r.vec, irq_acknowledge_n)
            if (!r.wr) `CHK("drive", 1'b0, data_oe)
            if (wait_states_complete_n === 1'b0) seen = 1'b1;
            tick(40);
        end
        lat = n;
        // With two or more waits one extra cycle samples ready after the software waits.
        if (r.x) `CHK("stretch", 1'b1, lat > r.w + 3)
        else `CHK("latency", r.w + 2 + (r.w >= 3'h2), lat)
        if (!r.wr) `CHK("rdata", r.d, rdata)
        `CHK("wsc", r.w >= 3'h2, seen)
        @(negedge clk);
        `CHK("idle", 4'hF, {program_space_select_n, data_space_select_n, io_space_select_n, wait_states_complete_n})
    endtask : acc
    initial begin
        do_reset;
        `CHK("fetch", RESET_FETCH_ADDR, fetch_start_addr)
        `CHK("rom", 2'h1, {rom_internal, processor_mode_status})
        `CHK("rest", 4'hF, {memory_strobe_n, io_strobe_n, rw_o, bus_grant_ack_n})
        for (int i = 0; i < 7; i++) acc(rows[i], 1'b0);
        // Hold is requested mid-access; the grant must wait for the end of it.
        acc(rows[6], 1'b1);
        n = 0;
        while (bus_grant_ack_n !== 1'b0) tick(20);
        `CHK("hold", 4'h0, {ctrl_oe, addr_oe, data_oe, req_ready})
        hold_req_n = 1'b1;
        repeat (6) @(negedge clk);
        `CHK("release", 2'h3, {bus_grant_ack_n, ctrl_oe})
        output_disable_n = 1'b0;
        repeat (4) @(negedge clk);
        `CHK("off", 1'b0, ctrl_oe)
        output_disable_n = 1'b1;
        rom_map_select = 1'b0;
        do_reset;
        rom_map_select = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("rom0", 2'h2, {rom_internal, processor_mode_status})
        req_waits = 3'h0;
        offer(EMB_SPACE_PROG, 1'b0, 1'b0, 23'h00C000);
        seen = 1'b0;
        hit = 1'b0;
        repeat (4) begin
            if (program_space_select_n === 1'b0) seen = 1'b1;
            if (done === 1'b1) hit = 1'b1;
            @(negedge clk);
        end
        `CHK("rom hit", 2'h1, {seen, hit})
        mode_override_en = 1'b1;
        mode_override_val = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("override", 2'h1, {rom_internal, processor_mode_status})
        give_verdict;
    end
endmodule : external_memory_bus_control_tb
`default_nettype wire
